// ### dv/led_cfg_sva.sv
// Port-level assertion checker for the LED driver core.
`timescale 1ns/1ps
module led_cfg_sva #(
   parameter integer TIMEOUT_CYCLES = 2000
) (
   input wire        CLK,
   input wire        RESET_N,
   input wire        SERIAL_IN,
   input wire        SERIAL_SHIFT_CLOCK,
   input wire        LATCH_STROBE,
   input wire        GRAYSCALE_CLOCK,
   input wire        OVER_TEMP,
   input wire [15:0] LOAD_OK,
   input wire        SERIAL_OUT_PIN,
   input wire [15:0] OUT_ON,
   input wire        HIGH_CURRENT_BAND,
   input wire [6:0]  GAIN_MANTISSA
);
   reg  [2:0]  pin_d_r;
   reg  [4:0]  cnt_r;
   reg  [4:0]  nld_r;
   reg  [3:0]  sev_r;
   reg  [3:0]  sle_r;
   reg  [15:0] sh_r;
   reg  [15:0] cfg_r;
   reg  [31:0] gidle_r;
   wire        rise    = SERIAL_SHIFT_CLOCK & ~pin_d_r[2];
   wire        stb_fall = ~LATCH_STROBE & pin_d_r[1];
   wire [3:0]  cmd     = cnt_r[4:1];

   // ======================================================
   // Shadow of the serial chain, command count and configuration word.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         {pin_d_r, cnt_r, nld_r, sh_r, gidle_r} <= 61'h0;
         {sev_r, sle_r} <= 8'hFF;
         cfg_r <= 16'h02AD;
      end else begin
         pin_d_r <= {SERIAL_SHIFT_CLOCK, LATCH_STROBE, GRAYSCALE_CLOCK};
         if (rise) sh_r <= {sh_r[14:0], SERIAL_IN};
         sev_r <= (rise | stb_fall) ? 4'h0 : sev_r + {3'h0, sev_r != 4'hF};
         sle_r <= stb_fall ? 4'h0 : sle_r + {3'h0, sle_r != 4'hF};
         gidle_r <= (GRAYSCALE_CLOCK & ~pin_d_r[0]) ? 32'h0 : gidle_r + {31'h0, gidle_r != 32'hFFFFFFFF};
         cnt_r <= stb_fall ? 5'h0 : cnt_r + {4'h0, rise & LATCH_STROBE};
         nld_r <= (stb_fall && (cmd == 4'h2 || cmd == 4'h4)) ? 5'h0 : nld_r + {4'h0, rise && nld_r != 5'h1F};
         if (stb_fall && cmd == 4'h5) cfg_r <= {^sh_r, 1'b0, sh_r[13:2], 1'b0, sh_r[0]};
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   // ======================================================
   // Properties.
   property p_rst_cfg; $rose(RESET_N) |-> HIGH_CURRENT_BAND && GAIN_MANTISSA == 7'h2B; endproperty
   property p_rst_out; $rose(RESET_N) |-> OUT_ON == 16'h0000 && !SERIAL_OUT_PIN; endproperty
   property p_cfg_pins; sle_r == 4'hF |-> HIGH_CURRENT_BAND == cfg_r[9] && GAIN_MANTISSA == cfg_r[8:2]; endproperty
   property p_rd_cfg; stb_fall && cmd == 4'h2 |-> ##7 SERIAL_OUT_PIN == cfg_r[15]; endproperty
   property p_shift; sev_r == 4'h7 && nld_r >= 5'h10 |-> SERIAL_OUT_PIN == sh_r[15]; endproperty
   property p_sout_when; $changed(SERIAL_OUT_PIN) |-> sev_r <= 4'h7; endproperty
   property p_detect_on; stb_fall && cmd == 4'h3 |-> ##[1:8] (OUT_ON == 16'hFFFF) [*8]; endproperty
   property p_timeout; !cfg_r[0] && gidle_r > TIMEOUT_CYCLES + 8 |-> OUT_ON == 16'h0000; endproperty

   a_rst_cfg: assert property (p_rst_cfg) else $error("config pins wrong after reset");
   a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
   a_cfg_pins: assert property (p_cfg_pins) else $error("gain pins differ from written word");
   a_rd_cfg: assert property (p_rd_cfg) else $error("parity bit wrong on config read");
   a_shift: assert property (p_shift) else $error("serial out does not follow chain");
   a_sout_when: assert property (p_sout_when) else $error("serial out moved without cause");
   a_detect_on: assert property (p_detect_on) else $error("detection did not turn outputs on");
   a_timeout: assert property (p_timeout) else $error("outputs on after clock loss");

   c_detect: cover property (stb_fall && cmd == 4'h3);
   c_read: cover property (stb_fall && cmd == 4'h2);
   c_blank: cover property (!cfg_r[0] && gidle_r > TIMEOUT_CYCLES + 8);
endmodule // led_cfg_sva

bind led_driver_core led_cfg_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (
   .CLK(CLK), .RESET_N(RESET_N), .SERIAL_IN(SERIAL_IN), .SERIAL_SHIFT_CLOCK(SERIAL_SHIFT_CLOCK),
   .LATCH_STROBE(LATCH_STROBE), .GRAYSCALE_CLOCK(GRAYSCALE_CLOCK), .OVER_TEMP(OVER_TEMP), .LOAD_OK(LOAD_OK),
   .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .OUT_ON(OUT_ON), .HIGH_CURRENT_BAND(HIGH_CURRENT_BAND),
   .GAIN_MANTISSA(GAIN_MANTISSA));

// ### dv/led_driver_config_and_error_detect_tb.sv
// Self-checking bench for the LED driver configuration and fault paths.
`timescale 1ns/1ps
module led_driver_config_and_error_detect_tb;
   reg         clk;
   reg         reset_n;
   reg         gs_clk;
   reg         gs_en;
   reg         over_temp;
   reg  [15:0] load_ok;
   wire        sin;
   wire        sclk;
   wire        stb;
   wire        sout;
   wire [15:0] out_on;
   wire        band;
   wire [6:0]  gain;
   reg  [15:0] rd;
   integer     bad_count;
   integer     total_checks;
   integer     i;

   serial_host u_host (.clk(clk), .sout(sout), .sin(sin), .sclk(sclk), .stb(stb));

   led_driver_core #(.TIMEOUT_CYCLES(2000), .DETECT_CYCLES(20)) u_dut (
      .CLK(clk), .RESET_N(reset_n), .SERIAL_IN(sin), .SERIAL_SHIFT_CLOCK(sclk), .LATCH_STROBE(stb),
      .GRAYSCALE_CLOCK(gs_clk), .OVER_TEMP(over_temp), .LOAD_OK(load_ok), .SERIAL_OUT_PIN(sout),
      .OUT_ON(out_on), .HIGH_CURRENT_BAND(band), .GAIN_MANTISSA(gain));

   // ======================================================
   // Clocks: the grayscale clock stands low while disabled.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      gs_clk = 1'b0;
      #3.5;
      forever #80 gs_clk = gs_en & ~gs_clk;
   end

   // ======================================================
   // Shared tasks.
   task check(input [15:0] seen, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task read_cfg(input [15:0] exp);
      begin
         u_host.send(16'h0000, 4);
         u_host.read(rd);
         check(rd, exp);
      end
   endtask
   // Sixteen pushes: even ones carry a, odd ones b; the last is a global latch.
   task load(input [15:0] a, input [15:0] b);
      begin
         for (i = 0; i < 15; i = i + 1) u_host.send(i[0] ? b : a, 1);
         u_host.send(b, 2);
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d, mismatches %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask

   // Watchdog well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      bad_count = bad_count + 1;
      give_verdict;
   end

   // ======================================================
   // Test sequence.
   initial begin
      bad_count = 0;
      total_checks = 0;
      reset_n = 1'b0;
      gs_en = 1'b0;
      over_temp = 1'b0;
      load_ok = 16'hA5F0;
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1'b1;
      check({8'h00, band, gain}, 16'h00AB);
      read_cfg(16'h02AD);
      $display("test reset values done");
      gs_en = 1'b1;
      u_host.write_cfg(16'h5FFE, 1'b0);
      check({8'h00, band, gain}, 16'h00FF);
      read_cfg(16'h1FFC);
      $display("test config write done");
      load(16'hFFFF, 16'h0000);
      u_host.tick(200);
      check(out_on, 16'hAAAA);
      gs_en = 1'b0;
      u_host.tick(2100);
      check(out_on, 16'h0000);
      gs_en = 1'b1;
      u_host.tick(300);
      check(out_on, 16'hAAAA);
      $display("test immediate load and clock loss done");
      u_host.send(16'h0000, 6);
      check(out_on, 16'hFFFF);
      u_host.fetch_err(rd);
      check(rd, 16'h5A0F);
      load_ok = 16'h3C3C;
      u_host.send(16'h0000, 6);
      check(out_on, 16'hFFFF);
      u_host.fetch_err(rd);
      check(rd, 16'hC3C3);
      $display("test open detection done");
      u_host.write_cfg(16'h5BFE, 1'b0);
      load(16'h0000, 16'hFFFF);
      u_host.tick(200);
      check(out_on, 16'hAAAA);
      u_host.write_cfg(16'h4FFE, 1'b0);
      u_host.tick(200);
      check(out_on, 16'h5555);
      $display("test deferred load done");
      over_temp = 1'b1;
      u_host.write_cfg(16'h0001, 1'b1);
      check({8'h00, band, gain}, 16'h0000);
      read_cfg(16'hC001);
      $display("test parity error and thermal flag done");
      give_verdict;
   end
endmodule // led_driver_config_and_error_detect_tb

// ### dv/serial_host.sv
// Host controller model that drives the serial shift chain.
`timescale 1ns/1ps
module serial_host (
   input  wire clk,
   input  wire sout,
   output reg  sin,
   output reg  sclk,
   output reg  stb
);
   // Pins idle low until the first transfer.
   initial begin
      sin = 1'b0;
      sclk = 1'b0;
      stb = 1'b0;
   end

   // Waits whole cycles and steps just past the edge.
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask

   // One bit: low phase with data set up, then a long high phase.
   task shift(input b);
      begin
         sin = b;
         sclk = 1'b0;
         tick(4);
         sclk = 1'b1;
         tick(6);
      end
   endtask

   // Sends a word MSB first with the strobe high over its last k bits.
   task send(input [15:0] w, input integer k);
      integer j;
      begin
         for (j = 15; j >= 0; j = j - 1) begin
            if (j == k - 1) stb = 1'b1;
            shift(w[j]);
         end
         stb = 1'b0;
         tick(8);
      end
   endtask

   // Writes a configuration word; bad inverts the parity it would send.
   task write_cfg(input [15:0] v, input bad);
      begin
         send({^v[14:0] ^ bad, v[14:0]}, 10);
      end
   endtask

   // Collects sixteen bits from the serial output.
   task read(output [15:0] r);
      integer j;
      begin
         r[15] = sout;
         for (j = 14; j >= 0; j = j - 1) begin
            shift(1'b0);
            r[j] = sout;
         end
      end
   endtask

   // Waits the settling time after detection, then fetches the fault codes.
   task fetch_err(output [15:0] r);
      begin
         tick(400);
         send(16'h0000, 8);
         read(r);
      end
   endtask
endmodule // serial_host

// ### inc/led_cfg_map.vh
// Constants for the configuration word, serial commands and timing of the LED driver core.
// Overview of operation
// R1 - Detect command turns all outputs on briefly.
// R2 - Host waits two microseconds before reading errors.
// R3 - Read-error command shifts fault codes out serially.
// R4 - Fault code one only for on-but-open output.
// R5 - Bit 15 is even parity, reset zero.
// R6 - Host sets parity over other fifteen bits.
// R7 - Device sets parity bit when ones odd.
// R8 - Bit 14 tracks over-temperature, reset zero.
// R9 - Read configuration returns thermal flag.
// R10 - Bit 13 selects 16-bit or 12-bit counter.
// R11 - Mode 00: 64 passes plus 6-bit pass.
// R12 - Mode 01: 16 passes at quarter rate.
// R13 - Mode 10: 4 passes at sixteenth rate.
// R14 - Mode 11: one plain full-depth pass.
// R15 - Sync bit 0 defers load to cycle end.
// R16 - Sync bit 1 loads new data at once.
// R17 - Bits 9:2 decode band and 7-bit mantissa.
// R18 - Clock loss with bit 0 low blanks outputs.
// R19 - Reserved bit 1 ignored, reads zero.
`ifndef LED_CFG_MAP_VH
`define LED_CFG_MAP_VH

// ======================================================
// Configuration word layout and reset value.
`define CFG_RESET        16'h02AD
`define CFG_PARITY_BIT   15
`define CFG_THERMAL_BIT  14
`define CFG_DEPTH_BIT    13
`define CFG_MODE_HI      12
`define CFG_MODE_LO      11
`define CFG_SYNC_BIT     10
`define CFG_BAND_BIT     9
`define CFG_MANT_HI      8
`define CFG_MANT_LO      2
`define CFG_RSVD_BIT     1
`define CFG_TOUT_BIT     0

// ======================================================
// Command codes: shift clock rising edges counted while the strobe is high, halved.
`define CMD_DATA_LATCH   3'h0
`define CMD_GLOBAL_LATCH 3'h1
`define CMD_READ_CFG     3'h2
`define CMD_DETECT       3'h3
`define CMD_READ_ERR     3'h4
`define CMD_WRITE_CFG    3'h5

// ======================================================
// Counting modes.
`define MODE_64          2'h0
`define MODE_16          2'h1
`define MODE_4           2'h2
`define MODE_PLAIN       2'h3

// ======================================================
// Timing.
`define CLK_PERIOD_NS    5
`define DETECT_NS        2000
`define DETECT_CYC       ((`DETECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_MS       1000
`define TIMEOUT_CYC      (`TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ### verilog/led_driver_core.v
// LED driver core: serial command decoder, configuration word, fault detection and PWM outputs.
`timescale 1ns/1ps
`include "led_cfg_map.vh"

module led_driver_core #(
   parameter integer TIMEOUT_CYCLES = `TIMEOUT_CYC,
   parameter integer DETECT_CYCLES  = `DETECT_CYC
) (
   input  wire        CLK,
   input  wire        RESET_N,
   input  wire        SERIAL_IN,
   input  wire        SERIAL_SHIFT_CLOCK,
   input  wire        LATCH_STROBE,
   input  wire        GRAYSCALE_CLOCK,
   input  wire        OVER_TEMP,
   input  wire [15:0] LOAD_OK,
   output reg         SERIAL_OUT_PIN,
   output reg  [15:0] OUT_ON,
   output reg         HIGH_CURRENT_BAND,
   output reg  [6:0]  GAIN_MANTISSA
);

   // ======================================================
   // Pin synchronisers: two flops before any logic reads a pin.
   reg  [3:0]  pin_s1_r;
   reg  [3:0]  pin_s2_r;
   reg  [3:0]  pin_d_r;
   reg         temp_s1_r;
   reg         temp_s2_r;
   reg  [15:0] ok_s1_r;
   reg  [15:0] ok_s2_r;

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_s1_r  <= 4'h0;
         pin_s2_r  <= 4'h0;
         pin_d_r   <= 4'h0;
         temp_s1_r <= 1'b0;
         temp_s2_r <= 1'b0;
         ok_s1_r   <= 16'h0000;
         ok_s2_r   <= 16'h0000;
      end else begin
         pin_s1_r  <= {GRAYSCALE_CLOCK, LATCH_STROBE, SERIAL_SHIFT_CLOCK, SERIAL_IN};
         pin_s2_r  <= pin_s1_r;
         pin_d_r   <= pin_s2_r;
         temp_s1_r <= OVER_TEMP;
         temp_s2_r <= temp_s1_r;
         ok_s1_r   <= LOAD_OK;
         ok_s2_r   <= ok_s1_r;
      end
   end

   wire sdi_s     = pin_s2_r[0];
   wire shift_rise  = pin_s2_r[1] & ~pin_d_r[1];
   wire strobe_high = pin_s2_r[2];
   wire strobe_fall = ~pin_s2_r[2] & pin_d_r[2];
   wire gs_rise     = pin_s2_r[3] & ~pin_d_r[3];

   // ======================================================
   // Shift chain, command counter and configuration word.
   reg  [15:0] shift_r;
   reg  [3:0]  edge_cnt_r;
   reg  [15:0] cfg_r;
   reg  [15:0] err_r;
   reg  [15:0] pend_r [0:15];
   reg         pend_new_r;
   reg         detect_on_r;
   wire [2:0]  cmd = edge_cnt_r[3:1];
   integer     i;
   integer     k;
   wire        seq_end;
   wire        sync_now = cfg_r[`CFG_SYNC_BIT];
   wire        load_act = pend_new_r & (sync_now | seq_end); // R15 R16

   // Read-back image: live thermal flag, reserved bit as zero.
   wire [15:0] cfg_rd = {cfg_r[15], temp_s2_r, cfg_r[13:2], 1'b0, cfg_r[0]}; // R8 R9 R19

   // Shift on each shift clock rise except in a strobe fall cycle, count rises under the strobe, act on its fall.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         shift_r    <= 16'h0000;
         edge_cnt_r <= 4'h0;
         cfg_r      <= `CFG_RESET;
         pend_new_r <= 1'b0;
         for (i = 0; i < 16; i = i + 1) begin
            pend_r[i] <= 16'h0000;
         end
      end else begin
         if (load_act) begin
            pend_new_r <= 1'b0;
         end
         if (strobe_fall) begin
            edge_cnt_r <= 4'h0;
            case (cmd)
               `CMD_DATA_LATCH, `CMD_GLOBAL_LATCH: begin
                  for (i = 15; i > 0; i = i - 1) begin
                     pend_r[i] <= pend_r[i-1];
                  end
                  pend_r[0] <= shift_r;
                  if (cmd == `CMD_GLOBAL_LATCH) begin
                     pend_new_r <= 1'b1;
                  end
               end
               `CMD_READ_CFG: shift_r <= cfg_rd; // R9
               `CMD_READ_ERR: shift_r <= err_r; // R3
               `CMD_WRITE_CFG: begin
                  cfg_r                 <= {^shift_r, 1'b0, shift_r[13:2], 1'b0, shift_r[0]}; // R7 R19
                  cfg_r[`CFG_PARITY_BIT] <= ^shift_r; // R5 R6 R7
               end
               default: ;
            endcase
         end else if (shift_rise) begin
            shift_r <= {shift_r[14:0], sdi_s};
            if (strobe_high && edge_cnt_r != 4'hF) begin
               edge_cnt_r <= edge_cnt_r + 4'h1;
            end
         end
      end
   end

   // Serial output and gain outputs are registered copies.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SERIAL_OUT_PIN    <= 1'b0;
         HIGH_CURRENT_BAND <= 1'b1;
         GAIN_MANTISSA     <= 7'h2B;
      end else begin
         SERIAL_OUT_PIN    <= shift_r[15]; // R3
         HIGH_CURRENT_BAND <= cfg_r[`CFG_BAND_BIT]; // R17
         GAIN_MANTISSA     <= cfg_r[`CFG_MANT_HI:`CFG_MANT_LO]; // R17
      end
   end

   // ======================================================
   // Open-circuit detection window and fault capture.
   reg  [31:0] det_cnt_r;

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         det_cnt_r   <= 32'h00000000;
         detect_on_r <= 1'b0;
         err_r       <= 16'h0000;
      end else if (strobe_fall && cmd == `CMD_DETECT) begin
         detect_on_r <= 1'b1; // R1
         det_cnt_r   <= 32'h00000000;
      end else if (detect_on_r) begin
         if (det_cnt_r >= DETECT_CYCLES - 1) begin
            detect_on_r <= 1'b0;
            err_r       <= OUT_ON & ~ok_s2_r; // R4 R2
         end else begin
            det_cnt_r <= det_cnt_r + 32'h00000001;
         end
      end
   end

   // ======================================================
   // Grayscale clock loss watch.
   reg  [31:0] idle_cnt_r;
   reg         timed_out_r;
   wire        tout_en = ~cfg_r[`CFG_TOUT_BIT];
   wire        restart = timed_out_r & gs_rise;

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         idle_cnt_r  <= 32'h00000000;
         timed_out_r <= 1'b0;
      end else if (gs_rise) begin
         idle_cnt_r  <= 32'h00000000;
         timed_out_r <= 1'b0; // R18
      end else if (idle_cnt_r >= TIMEOUT_CYCLES - 1) begin
         timed_out_r <= tout_en; // R18
      end else begin
         idle_cnt_r <= idle_cnt_r + 32'h00000001;
      end
   end

   // ======================================================
   // Active pixel data and PWM compare.
   wire [15:0] seq_cnt;
   wire        seq_lsb;
   wire        depth12  = cfg_r[`CFG_DEPTH_BIT];
   wire [1:0]  mode     = cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
   reg  [15:0] act_r [0:15];

   pwm_sequencer u_seq (
      .clk         (CLK),
      .reset_n     (RESET_N),
      .restart     (restart),
      .tick        (gs_rise),
      .depth12     (depth12),
      .mode        (mode),
      .cnt_r       (seq_cnt),
      .lsb_pass_r  (seq_lsb),
      .cycle_end_r (seq_end)
   );

   // Decide one channel's drive from its value and the shared count.
   function pix_on;
      input [15:0] val;
      input [15:0] cnt;
      input        lsb;
      input [1:0]  md;
      input        d12;
      begin
         if (md == `MODE_PLAIN) begin
            pix_on = d12 ? (val[15:4] > cnt[11:0]) : (val > cnt); // R14
         end else if (lsb) begin
            pix_on = d12 ? (val[9:4] > cnt[5:0]) : (val[5:0] > cnt[5:0]); // R11
         end else begin
            pix_on = d12 ? (val[15:10] > cnt[5:0]) : (val[15:6] > cnt[9:0]); // R10
         end
      end
   endfunction

   // Copy pending data into the active set, now or at cycle end.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (k = 0; k < 16; k = k + 1) begin
            act_r[k] <= 16'h0000;
         end
      end else if (load_act) begin
         for (k = 0; k < 16; k = k + 1) begin
            act_r[k] <= pend_r[k]; // R15 R16
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_ch
         // Drive each output: forced on in detection, off after clock loss.
         always @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               OUT_ON[g] <= 1'b0;
            end else if (detect_on_r) begin
               OUT_ON[g] <= 1'b1; // R1
            end else if (timed_out_r) begin
               OUT_ON[g] <= 1'b0; // R18
            end else begin
               OUT_ON[g] <= pix_on(act_r[g], seq_cnt, seq_lsb, mode, depth12);
            end
         end
      end
   endgenerate

endmodule // led_driver_core

// ### verilog/pwm_sequencer.v
// Grayscale pass sequencer: produces the shared count that every channel compares against.
`timescale 1ns/1ps
`include "led_cfg_map.vh"

module pwm_sequencer (
   input  wire        clk,
   input  wire        reset_n,
   input  wire        restart,
   input  wire        tick,
   input  wire        depth12,
   input  wire [1:0]  mode,
   output reg  [15:0] cnt_r,
   output reg         lsb_pass_r,
   output reg         cycle_end_r
);

   reg  [3:0]  pre_r;
   reg  [5:0]  pass_r;
   reg  [3:0]  pre_lim;
   reg  [5:0]  pass_lim;
   reg  [15:0] msb_max;
   reg  [15:0] plain_max;

   // Pass limits, prescale and counter span per mode and depth.
   always @* begin
      pre_lim   = (mode == `MODE_16) ? 4'h3 : (mode == `MODE_4) ? 4'hF : 4'h0; // R12 R13
      pass_lim  = (mode == `MODE_16) ? 6'h0F : (mode == `MODE_4) ? 6'h03 : 6'h3F; // R11 R12 R13
      msb_max   = depth12 ? 16'h003F : 16'h03FF; // R10
      plain_max = depth12 ? 16'h0FFF : 16'hFFFF; // R14
   end

   // Step the count on grayscale clock rises, prescaled in modes 01 and 10 outside the 6-bit pass, which ends a cycle; in mode 11 the plain count wrap does.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r       <= 16'h0000;
         pre_r       <= 4'h0;
         pass_r      <= 6'h00;
         lsb_pass_r  <= 1'b0;
         cycle_end_r <= 1'b0;
      end else if (restart) begin
         cnt_r       <= 16'h0000;
         pre_r       <= 4'h0;
         pass_r      <= 6'h00;
         lsb_pass_r  <= 1'b0;
         cycle_end_r <= 1'b0;
      end else begin
         cycle_end_r <= 1'b0;
         if (tick) begin
            if (mode == `MODE_PLAIN) begin
               lsb_pass_r <= 1'b0;
               if (cnt_r >= plain_max) begin
                  cnt_r       <= 16'h0000;
                  cycle_end_r <= 1'b1; // R14
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end else if (lsb_pass_r) begin
               if (cnt_r >= 16'h003F) begin
                  cnt_r       <= 16'h0000;
                  lsb_pass_r  <= 1'b0;
                  cycle_end_r <= 1'b1; // R11
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end else if (pre_r < pre_lim) begin
               pre_r <= pre_r + 4'h1; // R12 R13
            end else begin
               pre_r <= 4'h0;
               if (cnt_r >= msb_max) begin
                  cnt_r <= 16'h0000;
                  if (pass_r >= pass_lim) begin
                     pass_r     <= 6'h00;
                     lsb_pass_r <= 1'b1; // R11
                  end else begin
                     pass_r <= pass_r + 6'h01;
                  end
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
         end
      end
   end

endmodule // pwm_sequencer
